/* File: include/irq_regs.svh */
// Register indices, field positions, reset images and constants of the interrupt block
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

`define REG_CAL_PRIO 4'h0
`define REG_CHK_PRIO 4'h1
`define REG_BRN_PRIO 4'h2
`define REG_CHG_PRIO 4'h3
`define REG_USB_PRIO 4'h4
`define REG_VSTAT 4'h5
`define REG_FLAGS 4'h6
`define REG_ENABLES 4'h7
`define REG_CTL_ONE 4'h8
`define REG_TDIS 4'h9

`define NUM_SRC 7
`define NUM_PRIO_REGS 5

`define MASK_CAL 16'h0700
`define MASK_CHK 16'h7770
`define MASK_BRN 16'h0007
`define MASK_CHG 16'h0070
`define MASK_USB 16'h0700

`define RST_CAL 16'h0400
`define RST_CHK 16'h4440
`define RST_BRN 16'h0004
`define RST_CHG 16'h0040
`define RST_USB 16'h0400

`define LSB_CAL 8
`define LSB_CHK 12
`define LSB_SER2 8
`define LSB_SER1 4
`define LSB_BRN 0
`define LSB_CHG 4
`define LSB_USB 8

`define UNACC_BIT 15
`define CAPSEL_BIT 13
`define LVL_LSB 8
`define NEST_BIT 15
`define TRAP_FLAG_MASK 16'h0003

`define VEC_BASE 8'h08
`define VEC_CAL 8'h3E
`define VEC_CHK 8'h43
`define VEC_SER1 8'h49
`define VEC_SER2 8'h4A
`define VEC_BRN 8'h50
`define VEC_CHG 8'h55
`define VEC_USB 8'h5A
`define VEC_TRAP0 8'h02
`define VEC_TRAP1 8'h03

`define LVL_TRAP0 4'hD
`define LVL_TRAP1 4'hE
`define LVL_USER_TOP 4'h7
`define STACK_DEPTH 8

`endif

/* File: include/irq_pkg.sv */
// Shared types of the interrupt controller and its processor end
package irq_pkg;
	typedef logic [2:0] prio_t;
	typedef logic [3:0] lvl_t;
	typedef logic [7:0] vec_t;
	typedef logic [15:0] word_t;
endpackage

/* File: include/irq_link_if.sv */
// Link between the interrupt controller and the processor core
`timescale 1ns/1ps
`default_nettype none
interface irq_link_if;
	logic req;
	irq_pkg::lvl_t req_lvl;
	irq_pkg::vec_t req_vec;
	logic nest_dis;
	logic ack;
	irq_pkg::lvl_t cpu_lvl;
	logic busy;
	modport ctrl (output req, output req_lvl, output req_vec, output nest_dis,
		input ack, input cpu_lvl, input busy);
	modport cpu (input req, input req_lvl, input req_vec, input nest_dis,
		output ack, output cpu_lvl, output busy);
endinterface
`default_nettype wire

/* File: verilog/irq_ctrl.sv */
// Interrupt controller end: priorities, flags, arbitration and vector status
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "irq_regs.svh"
`default_nettype none
module irq_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [1:0] wb_sel_i,
	input wire logic [15:0] wb_dat_i,
	output logic [15:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [6:0] src_evt_i,
	input wire logic [1:0] trap_evt_i,
	irq_link_if.ctrl lnk
);

	irq_pkg::word_t prio_r [0:4];
	logic [6:0] flag_r;
	logic [6:0] en_r;
	logic [1:0] trap_r;
	logic nest_dis_r;
	logic capsel_r;
	irq_pkg::word_t tdis_r;
	irq_pkg::vec_t last_vec_r;
	irq_pkg::vec_t offer_vec_r;
	logic ack_r;
	irq_pkg::word_t rdat_r;

	logic wr;
	irq_pkg::word_t wmask;
	irq_pkg::prio_t best_lvl;
	irq_pkg::vec_t best_vec;
	logic user_ok;
	logic trap_ok;
	irq_pkg::lvl_t trap_lvl;
	irq_pkg::vec_t trap_vec;
	logic unacc;
	irq_pkg::word_t stat_word;
	irq_pkg::word_t rd_word;

	function automatic irq_pkg::word_t impl_mask(input int i);
		irq_pkg::word_t m [0:4];
		m = '{`MASK_CAL, `MASK_CHK, `MASK_BRN, `MASK_CHG, `MASK_USB};
		impl_mask = m[i];
	endfunction
	function automatic irq_pkg::word_t rst_image(input int i);
		irq_pkg::word_t r [0:4];
		r = '{`RST_CAL, `RST_CHK, `RST_BRN, `RST_CHG, `RST_USB};
		rst_image = r[i];
	endfunction
	function automatic irq_pkg::word_t merge(input irq_pkg::word_t old,
		input irq_pkg::word_t nw, input irq_pkg::word_t m);
		merge = (old & ~m) | (nw & m);
	endfunction
	// Sources held in ascending vector order so a strict compare keeps the lowest
	function automatic irq_pkg::vec_t src_vec(input int i);
		irq_pkg::vec_t v [0:6];
		v = '{`VEC_CAL, `VEC_CHK, `VEC_SER1, `VEC_SER2, `VEC_BRN, `VEC_CHG, `VEC_USB};
		src_vec = v[i];
	endfunction
	function automatic irq_pkg::prio_t src_lvl(input int i);
		irq_pkg::prio_t l [0:6];
		l = '{prio_r[0][`LSB_CAL +: 3], prio_r[1][`LSB_CHK +: 3], prio_r[1][`LSB_SER1 +: 3],
			prio_r[1][`LSB_SER2 +: 3], prio_r[2][`LSB_BRN +: 3], prio_r[3][`LSB_CHG +: 3],
			prio_r[4][`LSB_USB +: 3]};
		src_lvl = l[i];
	endfunction
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// Write lands on the edge that raises ack, one edge before the master samples it
	assign wr = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else if (ce_i) begin
			ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r <= 16'h0000;
		end else if (ce_i && wb_cyc_i && wb_stb_i && !ack_r) begin
			rdat_r <= rd_word;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < `NUM_PRIO_REGS; i++) begin
			if (rst_i) begin
				prio_r[i] <= rst_image(i);
			end else if (wr && wb_adr_i == 4'(i)) begin
				prio_r[i] <= merge(prio_r[i], wb_dat_i, wmask & impl_mask(i));
			end
		end
	end

	// Hardware set wins over a same-cycle software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_r <= 7'h00;
		end else if (ce_i) begin
			if (wr && wb_adr_i == `REG_FLAGS) begin
				flag_r <= (flag_r & ~(wb_dat_i[6:0] & wmask[6:0])) | src_evt_i;
			end else begin
				flag_r <= flag_r | src_evt_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r <= 7'h00;
		end else if (wr && wb_adr_i == `REG_ENABLES) begin
			en_r <= 7'(merge({9'h000, en_r}, wb_dat_i, wmask));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trap_r <= 2'h0;
		end else if (ce_i) begin
			if (wr && wb_adr_i == `REG_CTL_ONE) begin
				trap_r <= (trap_r & ~(wb_dat_i[1:0] & wmask[1:0])) | trap_evt_i;
			end else begin
				trap_r <= trap_r | trap_evt_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nest_dis_r <= 1'b0;
		end else if (wr && wb_adr_i == `REG_CTL_ONE && wb_sel_i[1]) begin
			nest_dis_r <= wb_dat_i[`NEST_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			capsel_r <= 1'b0;
		end else if (wr && wb_adr_i == `REG_VSTAT && wb_sel_i[1]) begin
			capsel_r <= wb_dat_i[`CAPSEL_BIT];
		end
	end

	// Timed disable: count loaded by software, runs down one per cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tdis_r <= 16'h0000;
		end else if (ce_i) begin
			if (wr && wb_adr_i == `REG_TDIS) begin
				tdis_r <= merge(tdis_r, wb_dat_i, wmask);
			end else if (tdis_r != 16'h0000) begin
				tdis_r <= tdis_r - 16'h0001;
			end
		end
	end

	// Level zero never beats best_lvl, so it stays disabled
	always_comb begin
		best_lvl = 3'h0;
		best_vec = 8'h00;
		for (int i = 0; i < `NUM_SRC; i++) begin
			if (flag_r[i] && en_r[i] && src_lvl(i) > best_lvl) begin
				best_lvl = src_lvl(i);
				best_vec = src_vec(i);
			end
		end
	end

	always_comb begin
		trap_ok = 1'b0;
		trap_lvl = `LVL_TRAP0;
		trap_vec = `VEC_TRAP0;
		if (trap_r[1]) begin
			trap_lvl = `LVL_TRAP1;
			trap_vec = `VEC_TRAP1;
		end
		// Traps ignore level seven, timed disable and nesting disable
		if (trap_r != 2'h0 && trap_lvl > lnk.cpu_lvl) begin
			trap_ok = 1'b1;
		end
	end

	always_comb begin
		user_ok = best_lvl != 3'h0 && {1'b0, best_lvl} > lnk.cpu_lvl;
		if (tdis_r != 16'h0000 && {1'b0, best_lvl} < `LVL_USER_TOP) begin
			user_ok = 1'b0;
		end
		if (nest_dis_r && lnk.busy) begin
			user_ok = 1'b0;
		end
	end

	assign lnk.req = trap_ok || user_ok;
	assign lnk.req_lvl = trap_ok ? trap_lvl : {1'b0, best_lvl};
	assign lnk.req_vec = trap_ok ? trap_vec : best_vec;
	assign lnk.nest_dis = nest_dis_r;

	// Level rises with the take, so req is gone by ack; keep the offered vector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			offer_vec_r <= `VEC_BASE;
			last_vec_r <= `VEC_BASE;
		end else if (ce_i) begin
			offer_vec_r <= lnk.req_vec;
			if (lnk.ack && offer_vec_r >= `VEC_BASE) begin
				last_vec_r <= offer_vec_r;
			end
		end
	end
	assign unacc = best_lvl != 3'h0 && lnk.cpu_lvl >= {1'b0, best_lvl};
	always_comb begin
		stat_word = 16'h0000;
		stat_word[`UNACC_BIT] = unacc;
		stat_word[`CAPSEL_BIT] = capsel_r;
		stat_word[`LVL_LSB +: 4] = lnk.cpu_lvl;
		if (capsel_r) begin
			stat_word[6:0] = 7'(best_vec - `VEC_BASE);
		end else begin
			stat_word[6:0] = 7'(last_vec_r - `VEC_BASE);
		end
	end

	always_comb begin
		case (wb_adr_i)
			`REG_CAL_PRIO: rd_word = prio_r[0];
			`REG_CHK_PRIO: rd_word = prio_r[1];
			`REG_BRN_PRIO: rd_word = prio_r[2];
			`REG_CHG_PRIO: rd_word = prio_r[3];
			`REG_USB_PRIO: rd_word = prio_r[4];
			`REG_VSTAT: rd_word = stat_word;
			`REG_FLAGS: rd_word = {9'h000, flag_r};
			`REG_ENABLES: rd_word = {9'h000, en_r};
			`REG_CTL_ONE: rd_word = {nest_dis_r, 13'h0000, trap_r};
			`REG_TDIS: rd_word = tdis_r;
			default: rd_word = 16'h0000;
		endcase
	end

endmodule
`default_nettype wire

/* File: verilog/irq_cpu_end.sv */
// Processor end: accepts requests, stacks and restores the CPU priority level
`timescale 1ns/1ps
`include "irq_regs.svh"
`default_nettype none
module irq_cpu_end (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	irq_link_if.cpu lnk,
	input wire logic ret_i,
	input wire logic level_wr_i,
	input wire logic [3:0] level_i,
	output logic taken_o,
	output logic [7:0] vector_o,
	output logic [3:0] level_o,
	output logic [3:0] depth_o
);

	irq_pkg::lvl_t stk_r [0:`STACK_DEPTH-1];
	irq_pkg::lvl_t ipl_r;
	logic [3:0] depth_r;
	logic ack_r;
	irq_pkg::vec_t vec_r;
	logic take;

	// A full stack refuses further nesting rather than overwrite
	assign take = lnk.req && lnk.req_lvl > ipl_r && !ack_r &&
		depth_r != 4'(`STACK_DEPTH);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			vec_r <= 8'h00;
		end else if (ce_i) begin
			ack_r <= take;
			if (take) begin
				vec_r <= lnk.req_vec;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ipl_r <= 4'h0;
			depth_r <= 4'h0;
		end else if (ce_i) begin
			if (take) begin
				stk_r[3'(depth_r)] <= ipl_r;
				ipl_r <= lnk.req_lvl;
				depth_r <= depth_r + 4'h1;
			end else if (ret_i && depth_r != 4'h0) begin
				ipl_r <= stk_r[3'(depth_r - 4'h1)];
				depth_r <= depth_r - 4'h1;
			end else if (level_wr_i) begin
				ipl_r <= level_i;
			end
		end
	end

	assign lnk.ack = ack_r;
	assign lnk.cpu_lvl = ipl_r;
	assign lnk.busy = depth_r != 4'h0;
	assign taken_o = ack_r;
	assign vector_o = vec_r;
	assign level_o = ipl_r;
	assign depth_o = depth_r;

endmodule
`default_nettype wire

/* File: test/irq_link_checker.sv */
// Link assertions between controller and processor end
`timescale 1ns/1ps
`default_nettype none
module irq_link_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req,
	input wire irq_pkg::lvl_t req_lvl,
	input wire irq_pkg::vec_t req_vec,
	input wire logic nest_dis,
	input wire logic ack,
	input wire irq_pkg::lvl_t cpu_lvl,
	input wire logic busy
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_offer;
		req && !ack;
	endsequence
	sequence s_take;
		ack ##1 !ack;
	endsequence
	AST_OFFER_TAKEN: assert property (s_offer |=> s_take)
		else $error("offer not taken");
	AST_ABOVE_LEVEL: assert property (req |-> req_lvl > cpu_lvl)
		else $error("request not above level");
	AST_LEVEL_LOAD: assert property (ack |-> $past(req) && cpu_lvl == $past(req_lvl))
		else $error("level not loaded");
	AST_NONZERO: assert property (req |-> req_lvl != 4'h0)
		else $error("disabled level forwarded");
	AST_NEST: assert property (nest_dis && busy |-> !req || req_lvl > 4'h7)
		else $error("nested user request");
	AST_TRAP_VEC: assert property (req && req_lvl > 4'h7 |->
		(req_vec == 8'h02 && req_lvl == 4'hD) || (req_vec == 8'h03 && req_lvl == 4'hE))
		else $error("bad trap vector");
	AST_USER_VEC: assert property (req && req_lvl <= 4'h7 |-> req_vec >= 8'h08 && req_vec <= 8'h87)
		else $error("user vector out of range");
	AST_PUSH: assert property ($rose(busy) |-> ack)
		else $error("stack grew without take");
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Bench joining controller and processor end
`timescale 1ns/1ps
`include "irq_regs.svh"
`default_nettype none
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ret = 1'b0, lwr = 1'b0;
	logic [3:0] adr = 4'h0, lvl = 4'h0;
	logic [15:0] dat = 16'h0000, rd;
	logic [6:0] evt = 7'h00;
	logic [1:0] trap = 2'h0;
	wire logic [15:0] dat_o;
	wire logic ack, taken;
	wire logic [7:0] vec;
	wire logic [3:0] lvl_o;
	wire logic [3:0] depth;
	int errors = 0, n_checks = 0;
	// Register rows: index, reset image, writable mask
	logic [3:0] r_adr [6] = '{`REG_CAL_PRIO, `REG_CHK_PRIO, `REG_BRN_PRIO,
		`REG_CHG_PRIO, `REG_USB_PRIO, 4'hF};
	logic [15:0] r_rst [6] = '{`RST_CAL, `RST_CHK, `RST_BRN, `RST_CHG, `RST_USB, 16'h0000};
	logic [15:0] r_msk [6] = '{`MASK_CAL, `MASK_CHK, `MASK_BRN, `MASK_CHG, `MASK_USB, 16'h0000};
	irq_link_if lnk();
	irq_ctrl i_irq_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(2'b11), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .src_evt_i(evt), .trap_evt_i(trap), .lnk(lnk));
	irq_cpu_end i_irq_cpu_end (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lnk(lnk),
		.ret_i(ret), .level_wr_i(lwr), .level_i(lvl), .taken_o(taken), .vector_o(vec),
		.level_o(lvl_o), .depth_o(depth));
	irq_link_checker i_irq_link_checker (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req),
		.req_lvl(lnk.req_lvl), .req_vec(lnk.req_vec), .nest_dis(lnk.nest_dis),
		.ack(lnk.ack), .cpu_lvl(lnk.cpu_lvl), .busy(lnk.busy));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			errors++;
			test_done();
		end
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic pulse(input logic [6:0] e, input logic [1:0] t, input logic r);
		@(posedge clk_i);
		evt <= e;
		trap <= t;
		ret <= r;
		@(posedge clk_i);
		evt <= 7'h00;
		trap <= 2'h0;
		ret <= 1'b0;
	endtask
	task automatic set_lvl(input logic [3:0] l);
		@(posedge clk_i);
		lwr <= 1'b1;
		lvl <= l;
		@(posedge clk_i);
		lwr <= 1'b0;
	endtask
	// Vector zero means no take may happen inside the window
	task automatic take(input logic [7:0] v, input logic [3:0] l, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (taken !== 1'b1 && n < lim);
		chk("taken", {15'h0000, v != 8'h00}, {15'h0000, taken});
		if (v != 8'h00) begin
			chk("vector", {8'h00, v}, {8'h00, vec});
			chk("level", {12'h000, l}, {12'h000, lvl_o});
		end
		if (v != 8'h00 && taken !== 1'b1) test_done();
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, r_adr[i], 16'h0000);
			chk("reset image", r_rst[i], rd);
			wb(1'b1, r_adr[i], 16'hFFFF);
			wb(1'b0, r_adr[i], 16'h0000);
			chk("mask", r_msk[i], rd);
			wb(1'b1, r_adr[i], r_rst[i]);
		end
		$display("register test done");
		wb(1'b1, `REG_FLAGS, 16'h007F);
		wb(1'b1, `REG_ENABLES, 16'h007F);
		pulse(7'h40, 2'h0, 1'b0);
		take(`VEC_USB, 4'h4, 20);
		pulse(7'h00, 2'h0, 1'b1);
		take(`VEC_USB, 4'h4, 20);
		wb(1'b1, `REG_FLAGS, 16'h0040);
		pulse(7'h00, 2'h0, 1'b1);
		take(8'h00, 4'h0, 8);
		$display("retake test done");
		set_lvl(4'h7);
		pulse(7'h01, 2'h0, 1'b0);
		take(8'h00, 4'h0, 8);
		wb(1'b1, `REG_VSTAT, 16'h2000);
		wb(1'b0, `REG_VSTAT, 16'h0000);
		chk("status", 16'hA736, rd);
		pulse(7'h00, 2'h1, 1'b0);
		take(`VEC_TRAP0, `LVL_TRAP0, 20);
		wb(1'b1, `REG_CTL_ONE, 16'h0001);
		pulse(7'h00, 2'h0, 1'b1);
		take(8'h00, 4'h0, 8);
		chk("restored level", 16'h0007, {12'h000, lvl_o});
		set_lvl(4'h0);
		take(`VEC_CAL, 4'h4, 20);
		wb(1'b1, `REG_FLAGS, 16'h0001);
		pulse(7'h00, 2'h0, 1'b1);
		$display("mask test done");
		wb(1'b1, `REG_CAL_PRIO, 16'h0600);
		wb(1'b1, `REG_USB_PRIO, 16'h0700);
		wb(1'b1, `REG_TDIS, 16'h0028);
		pulse(7'h01, 2'h0, 1'b0);
		take(8'h00, 4'h0, 8);
		pulse(7'h40, 2'h0, 1'b0);
		take(`VEC_USB, 4'h7, 20);
		wb(1'b1, `REG_FLAGS, 16'h0040);
		pulse(7'h00, 2'h0, 1'b1);
		take(`VEC_CAL, 4'h6, 60);
		wb(1'b1, `REG_FLAGS, 16'h0001);
		pulse(7'h00, 2'h0, 1'b1);
		$display("timed disable test done");
		wb(1'b1, `REG_CHK_PRIO, 16'h0550);
		pulse(7'h0E, 2'h0, 1'b0);
		take(`VEC_SER1, 4'h5, 20);
		wb(1'b1, `REG_FLAGS, 16'h0004);
		pulse(7'h00, 2'h0, 1'b1);
		take(`VEC_SER2, 4'h5, 20);
		wb(1'b1, `REG_FLAGS, 16'h0008);
		pulse(7'h00, 2'h0, 1'b1);
		take(8'h00, 4'h0, 8);
		$display("tie test done");
		wb(1'b1, `REG_CTL_ONE, 16'h8000);
		pulse(7'h01, 2'h0, 1'b0);
		take(`VEC_CAL, 4'h6, 20);
		pulse(7'h40, 2'h0, 1'b0);
		take(8'h00, 4'h0, 8);
		wb(1'b1, `REG_VSTAT, 16'h0000);
		wb(1'b0, `REG_VSTAT, 16'h0000);
		chk("last vector", 16'h0636, rd);
		wb(1'b1, `REG_CTL_ONE, 16'h0000);
		take(`VEC_USB, 4'h7, 20);
		chk("depth", 16'h0002, {12'h000, depth});
		$display("nesting test done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `REG_USB_PRIO, 16'h0000);
		chk("usb level", `RST_USB, rd);
		chk("cpu level", 16'h0000, {12'h000, lvl_o});
		$display("reset test done");
		test_done();
	end
endmodule
`default_nettype wire
